// [design/sds_cfg.svh]
// constants for the sigma-delta conversion sequencer
`ifndef SDS_CFG_SVH
`define SDS_CFG_SVH

`define SDS_NUM_CH       6
`define SDS_CH_W         3
`define SDS_RES_W        16
`define SDS_MOD_W        20
`define SDS_ADR_W        8
`define SDS_NUM_TRIG     4
`define SDS_IRQ_W        2

`define SDS_OFF_CSR      8'h00
`define SDS_OFF_CHSEL    8'h04
`define SDS_OFF_ISTAT    8'h08
`define SDS_OFF_IMASK    8'h0c
`define SDS_OFF_RES0     8'h10
`define SDS_RES_STRIDE   8'h04

`define SDS_CSR_GO       0
`define SDS_CSR_SCAN     1
`define SDS_CSR_TRG_LO   2
`define SDS_CSR_TRG_HI   3
`define SDS_CSR_IE       4
`define SDS_CSR_DMA      5
`define SDS_CSR_TRG_EN   6
`define SDS_CSR_END      7

`define SDS_IRQ_DONE     0
`define SDS_IRQ_ABORT    1

`define SDS_SAT_POS      16'h7fff
`define SDS_SAT_NEG      16'h8000

`endif

// [design/sds_pkg.sv]
// types of the sigma-delta conversion sequencer
`include "sds_cfg.svh"

package sds_pkg;

	typedef enum logic [2:0] {
		SDS_IDLE  = 3'b001,
		SDS_START = 3'b010,
		SDS_CONV  = 3'b100
	} sds_state_t;

	typedef struct packed {
		sds_state_t                                       state;
		logic                                             go;
		logic                                             scan;
		logic [1:0]                                       trig_sel;
		logic                                             trig_en;
		logic                                             irq_en;
		logic                                             dma_en;
		logic                                             end_flag;
		logic [`SDS_NUM_CH-1:0]                           chan_sel;
		logic [`SDS_CH_W-1:0]                             chan;
		logic [`SDS_IRQ_W-1:0]                            irq_stat;
		logic [`SDS_IRQ_W-1:0]                            irq_mask;
		logic [`SDS_NUM_CH-1:0][`SDS_RES_W-1:0]           results;
		logic                                             ack;
		logic [31:0]                                      rdat;
		logic                                             mod_start;
		logic                                             mod_abort;
		logic                                             dma_req;
	} sds_regs_t;

endpackage

// [design/sds_saturate.sv]
// clamps a wide signed modulator value to the stored result width
`timescale 1ns/1ns

module sds_saturate #(
	parameter int IN_W  = 20,
	parameter int OUT_W = 16
) (
	input  wire logic signed [IN_W-1:0]  value_i,
	output logic             [OUT_W-1:0] clamped_o
);

	localparam logic signed [IN_W-1:0] MAXV = {{(IN_W-OUT_W+1){1'b0}}, {(OUT_W-1){1'b1}}};
	localparam logic signed [IN_W-1:0] MINV = {{(IN_W-OUT_W+1){1'b1}}, {(OUT_W-1){1'b0}}};

	always_comb begin
		if (value_i > MAXV) begin
			clamped_o = MAXV[OUT_W-1:0];
		end else if (value_i < MINV) begin
			clamped_o = MINV[OUT_W-1:0];
		end else begin
			clamped_o = value_i[OUT_W-1:0];
		end
	end

endmodule

// [design/sds_chan_pick.sv]
// finds the lowest selected channel, optionally above a given index
`timescale 1ns/1ns

module sds_chan_pick #(
	parameter int N  = 6,
	parameter int IW = 3
) (
	input  wire logic [N-1:0]  sel_i,
	input  wire logic          use_after_i,
	input  wire logic [IW-1:0] after_i,
	output logic               found_o,
	output logic [IW-1:0]      idx_o
);

	always_comb begin
		found_o = 1'b0;
		idx_o   = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (sel_i[i] && (!use_after_i || (i > int'(after_i)))) begin
				found_o = 1'b1;
				idx_o   = IW'(i);
			end
		end
	end

endmodule

// [design/sds_sequencer.sv]
// conversion sequencer top: wishbone registers, channel stepping, irq and dma
//
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ns
`include "sds_cfg.svh"

module sds_sequencer (
	input  wire logic                         clk_i,
	input  wire logic                         sys_rst_i,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [`SDS_ADR_W-1:0]        wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	input  wire logic [`SDS_NUM_TRIG-1:0]     timer_trig_i,
	output logic                              mod_start_o,
	output logic                              mod_abort_o,
	output logic      [`SDS_CH_W-1:0]         mod_chan_o,
	input  wire logic                         mod_done_i,
	input  wire logic signed [`SDS_MOD_W-1:0] mod_result_i,
	output logic                              conv_done_irq_o,
	output logic                              dma_req_o,
	output logic                              irq_o
);

	sds_pkg::sds_regs_t r;
	sds_pkg::sds_regs_t next_r;

	logic                  low_found;
	logic [`SDS_CH_W-1:0]  low_idx;
	logic                  nxt_found;
	logic [`SDS_CH_W-1:0]  nxt_idx;
	logic [`SDS_RES_W-1:0] sat_value;

	sds_chan_pick #(
		.N  (`SDS_NUM_CH),
		.IW (`SDS_CH_W)
	) u_pick_low (
		.sel_i       (r.chan_sel),
		.use_after_i (1'b0),
		.after_i     (r.chan),
		.found_o     (low_found),
		.idx_o       (low_idx)
	);

	sds_chan_pick #(
		.N  (`SDS_NUM_CH),
		.IW (`SDS_CH_W)
	) u_pick_next (
		.sel_i       (r.chan_sel),
		.use_after_i (1'b1),
		.after_i     (r.chan),
		.found_o     (nxt_found),
		.idx_o       (nxt_idx)
	);

	sds_saturate #(
		.IN_W  (`SDS_MOD_W),
		.OUT_W (`SDS_RES_W)
	) u_sat (
		.value_i   (mod_result_i),
		.clamped_o (sat_value)
	);

	logic        bus_req;
	logic        bus_wr;
	logic        bus_rd;
	logic        trig_hit;
	logic [31:0] csr_value;

	assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;
	assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
	assign bus_rd  = bus_req && !wb_we_i;

	always_comb begin
		csr_value                  = '0;
		csr_value[`SDS_CSR_GO]     = r.go;
		csr_value[`SDS_CSR_SCAN]   = r.scan;
		csr_value[`SDS_CSR_TRG_LO] = r.trig_sel[0];
		csr_value[`SDS_CSR_TRG_HI] = r.trig_sel[1];
		csr_value[`SDS_CSR_IE]     = r.irq_en;
		csr_value[`SDS_CSR_DMA]    = r.dma_en;
		csr_value[`SDS_CSR_TRG_EN] = r.trig_en;
		csr_value[`SDS_CSR_END]    = r.end_flag;
	end

	assign trig_hit = r.trig_en && timer_trig_i[r.trig_sel];

	always_comb begin
		logic start_req;
		logic abort_req;
		logic pass_done;
		logic end_clr;
		start_req = 1'b0;
		abort_req = 1'b0;
		pass_done = 1'b0;
		end_clr   = 1'b0;
		next_r    = r;

		next_r.ack       = bus_req;
		next_r.mod_start = 1'b0;
		next_r.mod_abort = 1'b0;
		next_r.dma_req   = 1'b0;

		// read path; status clears on the read that returns it
		next_r.rdat = '0;
		if (bus_rd) begin
			case (wb_adr_i)
				`SDS_OFF_CSR: begin
					next_r.rdat = csr_value;
				end
				`SDS_OFF_CHSEL: begin
					next_r.rdat[`SDS_NUM_CH-1:0] = r.chan_sel;
				end
				`SDS_OFF_ISTAT: begin
					next_r.rdat[`SDS_IRQ_W-1:0] = r.irq_stat;
					next_r.irq_stat             = '0;
				end
				`SDS_OFF_IMASK: begin
					next_r.rdat[`SDS_IRQ_W-1:0] = r.irq_mask;
				end
				default: begin
					for (int i = 0; i < `SDS_NUM_CH; i++) begin
						if (wb_adr_i == `SDS_ADR_W'(`SDS_OFF_RES0 + i * `SDS_RES_STRIDE)) begin
							next_r.rdat[`SDS_RES_W-1:0] = r.results[i];
						end
					end
				end
			endcase
		end

		// write path
		if (bus_wr) begin
			case (wb_adr_i)
				`SDS_OFF_CSR: begin
					next_r.scan     = wb_dat_i[`SDS_CSR_SCAN];
					next_r.trig_sel = {wb_dat_i[`SDS_CSR_TRG_HI], wb_dat_i[`SDS_CSR_TRG_LO]};
					next_r.irq_en   = wb_dat_i[`SDS_CSR_IE];
					next_r.dma_en   = wb_dat_i[`SDS_CSR_DMA];
					next_r.trig_en  = wb_dat_i[`SDS_CSR_TRG_EN];
					end_clr = !wb_dat_i[`SDS_CSR_END];
					if (!wb_dat_i[`SDS_CSR_GO] && r.state != sds_pkg::SDS_IDLE) begin
						abort_req = 1'b1;
					end
					// writes to go in the wrong state are ignored
					if (wb_dat_i[`SDS_CSR_GO] && r.state == sds_pkg::SDS_IDLE) begin
						start_req = 1'b1;
					end
				end
				`SDS_OFF_CHSEL: begin
					next_r.chan_sel = wb_dat_i[`SDS_NUM_CH-1:0];
				end
				`SDS_OFF_IMASK: begin
					next_r.irq_mask = wb_dat_i[`SDS_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		if (trig_hit && r.state == sds_pkg::SDS_IDLE) begin
			start_req = 1'b1;
		end

		if (end_clr) begin
			next_r.end_flag = 1'b0;
		end

		case (r.state)
			sds_pkg::SDS_IDLE: begin
				if (start_req && low_found) begin
					next_r.go    = 1'b1;
					next_r.chan  = low_idx;
					next_r.state = sds_pkg::SDS_START;
				end
			end
			sds_pkg::SDS_START: begin
				next_r.mod_start = 1'b1;
				next_r.state     = sds_pkg::SDS_CONV;
			end
			sds_pkg::SDS_CONV: begin
				if (mod_done_i) begin
					next_r.results[r.chan] = sat_value;
					if (nxt_found) begin
						next_r.chan  = nxt_idx;
						next_r.state = sds_pkg::SDS_START;
					end else begin
						pass_done = 1'b1;
						if (r.scan && low_found) begin
							next_r.chan  = low_idx;
							next_r.state = sds_pkg::SDS_START;
						end else begin
							next_r.go    = 1'b0;
							next_r.state = sds_pkg::SDS_IDLE;
						end
					end
				end
			end
			default: begin
				next_r.go    = 1'b0;
				next_r.state = sds_pkg::SDS_IDLE;
			end
		endcase

		// abort has priority over any completion in the same cycle
		if (abort_req) begin
			pass_done        = 1'b0;
			next_r.go        = 1'b0;
			next_r.mod_start = 1'b0;
			next_r.mod_abort = 1'b1;
			next_r.state     = sds_pkg::SDS_IDLE;
			next_r.irq_stat[`SDS_IRQ_ABORT] = 1'b1;
		end

		// only at end of a whole pass
		// set wins over clear, request repeats
		if (pass_done) begin
			next_r.end_flag = 1'b1;
			if (r.irq_en) begin
				next_r.irq_stat[`SDS_IRQ_DONE] = 1'b1;
			end
			next_r.dma_req = r.dma_en;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r       <= '0;
			r.state <= sds_pkg::SDS_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign wb_ack_o        = r.ack;
	assign wb_dat_o        = r.rdat;
	assign mod_start_o     = r.mod_start;
	assign mod_abort_o     = r.mod_abort;
	assign mod_chan_o      = r.chan;
	assign dma_req_o       = r.dma_req;
	assign conv_done_irq_o = r.end_flag && r.irq_en;
	assign irq_o           = |(r.irq_stat & r.irq_mask);

endmodule

// [bench/sds_properties.sv]
// port assertions for the conversion sequencer
`timescale 1ns/1ns
module sds_properties (
	input wire logic        clk_i,
	input wire logic        sys_rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        mod_start_o,
	input wire logic        mod_abort_o,
	input wire logic        mod_done_i,
	input wire logic        conv_done_irq_o,
	input wire logic        dma_req_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("late ack");
	a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("long ack");
	a_rdata_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("stray read data");
	a_start_one_cycle: assert property (mod_start_o |=> !mod_start_o)
		else $error("long start");
	a_abort_one_cycle: assert property (mod_abort_o |=> !mod_abort_o)
		else $error("long abort");
	a_abort_no_start: assert property (mod_abort_o |-> !mod_start_o)
		else $error("start with abort");
	a_dma_after_done: assert property (dma_req_o |-> $past(mod_done_i))
		else $error("dma without done");
	a_irq_rise_cause: assert property ($rose(conv_done_irq_o) |-> $past(mod_done_i) || wb_ack_o)
		else $error("irq without cause");
	c_dma: cover property (dma_req_o);
	c_abort: cover property (mod_abort_o);
	c_irq: cover property ($rose(conv_done_irq_o));
endmodule

bind sds_sequencer sds_properties i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mod_start_o(mod_start_o),
	.mod_abort_o(mod_abort_o), .mod_done_i(mod_done_i), .conv_done_irq_o(conv_done_irq_o),
	.dma_req_o(dma_req_o));

// [bench/sds_mod_model.sv]
// modulator stand-in: answers each start after a set delay
`timescale 1ns/1ns
module sds_mod_model (
	input  wire logic               clk_i,
	input  wire logic               sys_rst_i,
	input  wire logic               start_i,
	input  wire logic               abort_i,
	input  wire logic [2:0]         chan_i,
	input  wire logic signed [19:0] raw_i,
	input  wire logic [7:0]         dly_i,
	output logic                    done_o,
	output logic signed [19:0]      result_o
);
	logic       busy;
	logic [7:0] cnt;
	// result toggles between answers so stale data never looks valid
	always @(posedge clk_i) begin
		done_o <= 1'b0;
		result_o <= ~result_o;
		if (sys_rst_i || abort_i) begin
			busy <= 1'b0;
			result_o <= '0;
		end else if (start_i) begin
			busy <= 1'b1;
			cnt <= dly_i;
		end else if (busy && cnt == 8'h0) begin
			busy <= 1'b0;
			done_o <= 1'b1;
			result_o <= raw_i + {17'h0, chan_i};
		end else if (busy) begin
			cnt <= cnt - 8'h1;
		end
	end
endmodule

// [bench/sds_sequencer_tb.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ns
module sds_sequencer_tb;
	logic               clk_i, sys_rst_i, cs, we, ack, ms, ma, ds, cdi, dma, irq;
	logic        [7:0]  adr, dly;
	logic        [3:0]  trig, sel;
	logic        [2:0]  ch;
	logic        [31:0] wd, rd, q;
	logic signed [19:0] res, raw;
	logic        [2:0]  exp_q[$];
	int                 errors, checked, dma_n, ab_n, n;
	sds_sequencer i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cs), .wb_stb_i(cs),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .timer_trig_i(trig), .mod_start_o(ms), .mod_abort_o(ma),
		.mod_chan_o(ch), .mod_done_i(ds), .mod_result_i(res), .conv_done_irq_o(cdi),
		.dma_req_o(dma), .irq_o(irq));
	sds_mod_model i_mod (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .start_i(ms), .abort_i(ma),
		.chan_i(ch), .raw_i(raw), .dly_i(dly), .done_o(ds), .result_o(res));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic report_and_stop;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		int k;
		k = 0;
		cs <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rd;
		cs <= 1'b0;
		@(posedge clk_i);
		if (k == 20) begin
			chk(0, 1, "bus hang");
			report_and_stop();
		end
	endtask
	task automatic wait_idle;
		int k;
		k = 0;
		do begin
			wb(0, 8'h00, 0);
			k++;
		end while (q[0] !== 1'b0 && k < 300);
		if (q[0] !== 1'b0) begin
			chk(0, 1, "idle timeout");
			report_and_stop();
		end
	endtask
	task automatic wait_q;
		for (n = 0; n < 2000 && exp_q.size() != 0; n++) @(posedge clk_i);
		chk(32'(exp_q.size()), 0, "start missing");
		if (n == 2000) report_and_stop();
	endtask
	function automatic logic [31:0] sat(input logic signed [19:0] v);
		if (v > 20'sd32767) return 32'h7fff;
		if (v < -20'sd32768) return 32'h8000;
		return {16'h0, v[15:0]};
	endfunction
	// each start pulse takes the oldest expected channel
	always @(posedge clk_i) begin
		if (ms === 1'b1 && exp_q.size() == 0) chk(1, 0, "stray start");
		else if (ms === 1'b1) chk(32'(ch), 32'(exp_q.pop_front()), "order");
		if (dma === 1'b1) dma_n++;
		if (ma === 1'b1) ab_n++;
	end
	initial begin
		sys_rst_i = 1'b1;
		{cs, we, adr, wd, trig, sel, dly, raw} = '0;
		{errors, checked, dma_n, ab_n} = '0;
		void'($urandom(32'h5db4));
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		wb(0, 8'h00, 0);
		chk(q, 0, "csr reset");
		wb(0, 8'h40, 0);
		chk(q, 0, "unmapped");
		// a write without byte lane 0 must leave the channel select alone
		wb(1, 8'h04, 32'h3f, 4'he);
		wb(0, 8'h04, 0);
		chk(q, 0, "sel gate");
		raw = 20'sh40000;
		dly = 8'd6;
		wb(1, 8'h0c, 32'h3);
		wb(1, 8'h04, 32'h2);
		exp_q.push_back(3'd1);
		wb(1, 8'h00, 32'h11);
		wb(0, 8'h00, 0);
		chk(q & 32'h1, 1, "go busy");
		wait_idle();
		chk(q & 32'h90, 32'h90, "end flag");
		chk(32'(irq & cdi), 1, "irq");
		wb(0, 8'h14, 0);
		chk(q, sat(raw + 20'sd1), "ch1");
		wb(0, 8'h08, 0);
		chk(q, 1, "status");
		wb(1, 8'h00, 32'h10);
		chk(32'(irq | cdi), 0, "cleared");
		$display("t1 done");
		wb(1, 8'h0c, 0);
		wb(1, 8'h04, 32'h16);
		for (int p = 1; p < 3; p++) begin
			raw = 20'($urandom_range(32'h1ffff)) - 20'sh10000;
			dly = 8'($urandom_range(6));
			exp_q.push_back(3'd1);
			exp_q.push_back(3'd2);
			exp_q.push_back(3'd4);
			wb(1, 8'h00, 32'hb1);
			wait_idle();
			chk(dma_n, p, "dma count");
			chk(32'({irq, cdi}), 1, "masked");
			for (int c = 1; c < 5; c++) begin
				if (c != 3) begin
					wb(0, 8'(16 + 4 * c), 0);
					chk(q, sat(raw + 20'(c)), "result");
				end
			end
		end
		$display("t2 done");
		wb(1, 8'h04, 32'h1);
		dly = 8'd10;
		for (int s = 0; s < 4; s++) begin
			wb(1, 8'h00, 32'h40 | 32'(s) << 2);
			exp_q.push_back(3'd0);
			trig <= 4'(1 << s);
			@(posedge clk_i);
			trig <= 4'h0;
			repeat (3) @(posedge clk_i);
			// retrigger while busy must be ignored
			trig <= 4'hf;
			@(posedge clk_i);
			trig <= 4'h0;
			wait_idle();
			chk(32'(exp_q.size()), 0, "trigger");
		end
		$display("t3 done");
		wb(1, 8'h04, 32'h7);
		dly = 8'd20;
		for (int i = 0; i < 7; i++) exp_q.push_back(3'(i % 3));
		wb(1, 8'h00, 32'h13);
		wait_q();
		wb(0, 8'h00, 0);
		chk(q & 32'h81, 32'h81, "scan runs");
		wb(1, 8'h00, 32'h12);
		@(posedge clk_i);
		chk(ab_n, 1, "abort");
		wb(0, 8'h08, 0);
		chk(q, 3, "abort status");
		exp_q.push_back(3'd0);
		wb(1, 8'h00, 32'h13);
		wait_q();
		wb(1, 8'h00, 0);
		$display("t4 done");
		report_and_stop();
	end
endmodule
